// ---- rcw_defs.vh ----
// rcw_defs.vh: constants of the reset-cause, watchdog and power-save block
//
// Functional notes
// - external pin reset in run: set external flag, clear sw/wdt/idle/sleep
// - software reset in run: set sw flag, clear external/wdt/idle/sleep
// - pin reset in sleep: set external and sleep, clear wdt and idle
// - pin reset in idle: set external and idle, clear wdt and sleep
// - interrupt wake from sleep sets only sleep flag, restart at its vector
// - interrupt wake loads that interrupt's vector into the program counter
// - watchdog counts ticks of the independent low-power rc clock
// - watchdog permanently on when config enable bit is one
// - enabled watchdog counts to overflow; overflow resets only in run
// - with config bit zero, register bit 5 enables the watchdog
// - timeout in sleep or idle wakes, sets wdt flag and state flag
// - power-save instruction operand selects sleep or idle
// - sleep stops cpu, peripheral clocks and oscillator; rc runs if wdt on
// - sleep exits on enabled interrupt, any reset, or watchdog timeout
// - sleep wake holds clock for start-up timer and pll lock
// - fast-class clock sources wake after the power-on delay only
// - low-power crystal kept through sleep wakes after power-on delay only
// - clock dead after delays: trap to fast rc if monitored, else stall
// - idle stops only the cpu clock
// - idle wake reapplies cpu clock at once, wdt wake resumes next instruction
// - interrupt idle wake and non-power-on resets in idle set idle flag
// - non-power-on reset during sleep sets the sleep flag
`ifndef RCW_DEFS_VH
`define RCW_DEFS_VH

// ==========================================================
// register map
`define RCW_RESET_CAUSE_REGISTER_OFF   16'h0740
`define RCW_RESET_CAUSE_REGISTER_RST   16'h0003
`define RCW_RESET_CAUSE_REGISTER_MASK  16'hc0ff
`define RCW_B_TRAP     15
`define RCW_B_IOP      14
`define RCW_B_EXT      7
`define RCW_B_SW       6
`define RCW_B_WATCHDOG_SOFT_ENABLE   5
`define RCW_B_WATCHDOG_TIMEOUT_FLAG     4
`define RCW_B_SLEEP    3
`define RCW_B_IDLE     2
`define RCW_B_BOR      1
`define RCW_B_POR      0

// ==========================================================
// restart addresses and operands
`define RCW_RESET_PC   24'h000000
`define RCW_CFAIL_PC   24'h000004
`define RCW_PS_SLEEP   1'b0
`define RCW_PS_IDLE    1'b1

// ==========================================================
// clock source classes
`define RCW_OSC_FAST   2'd0
`define RCW_OSC_XTAL   2'd1
`define RCW_OSC_PLL    2'd2
`define RCW_OSC_LP     2'd3

// ==========================================================
// timing
`define RCW_CLK_MHZ    250
`define RCW_POWER_ON_DELAY_NS    10000
`define RCW_POR_CYC    ((`RCW_POWER_ON_DELAY_NS * `RCW_CLK_MHZ + 999) / 1000)
`define RCW_POWER_UP_TIMER_US    4000
`define RCW_POWER_UP_TIMER_CYC   (`RCW_POWER_UP_TIMER_US * `RCW_CLK_MHZ)
`define RCW_OST_CYC    1024
`define RCW_LOCK_CYC   512

`endif

// ---- rcw_ctrl.v ----
// rcw_ctrl.v: reset-cause flags, watchdog and sleep/idle clock control
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_defs.vh"

module rcw_ctrl #(
  parameter WDT_BITS      = 16,
  parameter POWER_UP_TIMER_UNIT_CYC = `RCW_POWER_UP_TIMER_CYC,
  parameter OST_CYC       = `RCW_OST_CYC,
  parameter LOCK_CYC      = `RCW_LOCK_CYC
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        external_reset_pin_n,
  input  wire        low_power_rc_clock,
  input  wire        watchdog_config_enable,
  input  wire        watchdog_clear_instr,
  input  wire        power_save_instr,
  input  wire        power_save_mode,
  input  wire        sw_reset_req,
  input  wire        brown_out_evt,
  input  wire        trap_conflict_evt,
  input  wire        illegal_op_evt,
  input  wire        irq_wake,
  input  wire [23:0] irq_vector,
  input  wire [23:0] sleep_pc,
  input  wire [1:0]  current_osc_select,
  input  wire [1:0]  osc_source_config,
  input  wire [1:0]  power_up_sel,
  input  wire        low_power_crystal_kept,
  input  wire        osc_running,
  input  wire        pll_lock,
  input  wire        clock_fail_monitor,
  output reg         sys_reset_out,
  output reg         restart_load,
  output reg  [23:0] restart_pc,
  output reg         restart_next,
  output reg         clk_fail_trap,
  output reg         fast_rc_clock_sel,
  output reg         cpu_clk_en,
  output reg         periph_clk_en,
  output reg         osc_en,
  output reg         low_power_rc_en,
  output wire [15:0] reset_cause_register,
  output wire        watchdog_active
);

  // ==========================================================
  // states
  localparam [2:0] ST_BOOT  = 3'd0;
  localparam [2:0] ST_RUN   = 3'd1;
  localparam [2:0] ST_SLEEP = 3'd2;
  localparam [2:0] ST_IDLE  = 3'd3;
  localparam [2:0] ST_DELAY = 3'd4;
  localparam [2:0] ST_STALL = 3'd5;

  // counts are worked out as integers, then cut to the delay width
  localparam integer POR_I  = `RCW_POR_CYC;
  localparam integer POWER_UP_TIMER_I = POWER_UP_TIMER_UNIT_CYC;
  localparam integer OST_I  = OST_CYC;
  localparam integer LOCK_I = LOCK_CYC;
  localparam [25:0] POR_C  = POR_I[25:0];
  localparam [25:0] POWER_UP_TIMER_C = POWER_UP_TIMER_I[25:0];
  localparam [25:0] OST_C  = OST_I[25:0];
  localparam [25:0] LOCK_C = LOCK_I[25:0];
  localparam [1:0]  PIN_RST = 2'b01;

  // ==========================================================
  // pin filters: bit 0 reset pin, bit 1 low-power rc clock
  wire [1:0] pins_in = {low_power_rc_clock, external_reset_pin_n};
  reg  [1:0] sy1_r;
  reg  [1:0] sy2_r;
  reg  [1:0] sy3_r;
  reg  [1:0] pin_r;
  reg  [1:0] pin_d_r;

  // a level counts only once stages two and three agree, which also
  // swallows single-sample glitches on the reset pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sy1_r[gi]   <= PIN_RST[gi];
          sy2_r[gi]   <= PIN_RST[gi];
          sy3_r[gi]   <= PIN_RST[gi];
          pin_r[gi]   <= PIN_RST[gi];
          pin_d_r[gi] <= PIN_RST[gi];
        end else begin
          sy1_r[gi] <= pins_in[gi];
          sy2_r[gi] <= sy1_r[gi];
          sy3_r[gi] <= sy2_r[gi];
          if (sy2_r[gi] == sy3_r[gi]) begin
            pin_r[gi] <= sy3_r[gi];
          end
          pin_d_r[gi] <= pin_r[gi];
        end
      end
    end
  endgenerate

  wire ext_fall = pin_d_r[0] & ~pin_r[0];
  wire pin_low  = ~pin_r[0];
  wire rc_tick  = pin_r[1] & ~pin_d_r[1];

  // ==========================================================
  // state registers
  reg [2:0]          state_r;
  reg [2:0]          state_nxt;
  reg [25:0]         dly_r;
  reg [25:0]         dly_nxt;
  reg [15:0]         flags_r;
  reg [15:0]         flags_nxt;
  reg [WDT_BITS-1:0] wdt_cnt_r;
  reg [WDT_BITS-1:0] wdt_cnt_nxt;
  reg [23:0]         res_pc_r;
  reg [23:0]         res_pc_nxt;
  reg                res_next_r;
  reg                res_next_nxt;
  reg                in_reset_r;
  reg                in_reset_nxt;
  reg                pll_wait_r;
  reg                pll_wait_nxt;
  reg                load_nxt;
  reg [23:0]         pc_nxt;
  reg                next_nxt;
  reg                trap_nxt;
  reg                frc_nxt;

  wire asleep  = (state_r == ST_SLEEP);
  wire idling  = (state_r == ST_IDLE);
  wire running = (state_r == ST_RUN);

  // ==========================================================
  // watchdog
  assign watchdog_active = watchdog_config_enable |
                           flags_r[`RCW_B_WATCHDOG_SOFT_ENABLE];
  wire wdt_counting = running | asleep | idling;
  wire wdt_ovf = watchdog_active & wdt_counting & rc_tick &
                 (&wdt_cnt_r);

  // counting stops outside run and power-save so a wake delay never
  // races a second timeout
  always @* begin
    wdt_cnt_nxt = wdt_cnt_r;
    if (watchdog_clear_instr | ~watchdog_active) begin
      wdt_cnt_nxt = {WDT_BITS{1'b0}};
    end else if (wdt_counting & rc_tick) begin
      wdt_cnt_nxt = wdt_cnt_r + {{(WDT_BITS-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // reset and wake causes
  wire sw_rst    = running & sw_reset_req;
  wire trap_rst  = running & (trap_conflict_evt | illegal_op_evt);
  wire wdt_rst   = running & wdt_ovf;
  wire any_reset = ext_fall | brown_out_evt | sw_rst | trap_rst | wdt_rst;
  wire wake_irq  = (asleep | idling) & irq_wake;
  wire wake_wdt  = (asleep | idling) & wdt_ovf;

  // flag update; hardware events are applied after the software write
  // so a set in the same cycle as a clear always survives
  always @* begin
    flags_nxt = flags_r;
    if (reg_wr && (reg_addr == `RCW_RESET_CAUSE_REGISTER_OFF)) begin
      flags_nxt = reg_wdata & `RCW_RESET_CAUSE_REGISTER_MASK;
    end
    if (brown_out_evt) begin
      flags_nxt[`RCW_B_POR] = 1'b0;
      flags_nxt[`RCW_B_BOR] = 1'b1;
      if (asleep) begin
        flags_nxt[`RCW_B_SLEEP] = 1'b1;
      end
      if (idling) begin
        flags_nxt[`RCW_B_IDLE] = 1'b1;
      end
    end
    if (ext_fall) begin
      flags_nxt[`RCW_B_EXT]   = 1'b1;
      flags_nxt[`RCW_B_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      flags_nxt[`RCW_B_SLEEP] = asleep;
      flags_nxt[`RCW_B_IDLE]  = idling;
      if (!asleep && !idling) begin
        flags_nxt[`RCW_B_SW] = 1'b0;
      end
    end else if (sw_rst) begin
      flags_nxt[`RCW_B_EXT]   = 1'b0;
      flags_nxt[`RCW_B_SW]    = 1'b1;
      flags_nxt[`RCW_B_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      flags_nxt[`RCW_B_IDLE]  = 1'b0;
      flags_nxt[`RCW_B_SLEEP] = 1'b0;
    end else if (wdt_rst) begin
      flags_nxt[`RCW_B_EXT]   = 1'b0;
      flags_nxt[`RCW_B_SW]    = 1'b0;
      flags_nxt[`RCW_B_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
      flags_nxt[`RCW_B_IDLE]  = 1'b0;
      flags_nxt[`RCW_B_SLEEP] = 1'b0;
    end
    if (!ext_fall && (wake_wdt || wake_irq)) begin
      if (wake_wdt) begin
        flags_nxt[`RCW_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      end
      if (asleep) begin
        flags_nxt[`RCW_B_SLEEP] = 1'b1;
      end else begin
        flags_nxt[`RCW_B_IDLE] = 1'b1;
      end
    end
    if (running & trap_conflict_evt) begin
      flags_nxt[`RCW_B_TRAP] = 1'b1;
    end
    if (running & illegal_op_evt) begin
      flags_nxt[`RCW_B_IOP] = 1'b1;
    end
  end

  assign reset_cause_register = flags_r;

  // ==========================================================
  // start-up delay of a given clock class
  function [25:0] start_dly;
    input [1:0] cls;
    input       lp_kept;
    input [1:0] power_up_timer_sel;
    reg   [25:0] pw;
    begin
      case (power_up_timer_sel)
        2'd0:    pw = 26'd0;
        2'd1:    pw = POWER_UP_TIMER_C;
        2'd2:    pw = {POWER_UP_TIMER_C[23:0], 2'b00};
        default: pw = {POWER_UP_TIMER_C[21:0], 4'b0000};
      endcase
      if ((cls == `RCW_OSC_FAST) || ((cls == `RCW_OSC_LP) && lp_kept)) begin
        start_dly = POR_C;
      end else if (cls == `RCW_OSC_PLL) begin
        start_dly = POR_C + pw + OST_C + LOCK_C;
      end else begin
        start_dly = POR_C + pw + OST_C;
      end
    end
  endfunction

  // power-on and brown-out restart from the configured source, all
  // other resets from the source that was running
  wire [1:0] rst_cls = brown_out_evt ? osc_source_config
                                     : current_osc_select;
  wire clk_ok = osc_running & (~pll_wait_r | pll_lock);

  // ==========================================================
  // sequencer
  always @* begin
    state_nxt    = state_r;
    dly_nxt      = dly_r;
    res_pc_nxt   = res_pc_r;
    res_next_nxt = res_next_r;
    in_reset_nxt = in_reset_r;
    pll_wait_nxt = pll_wait_r;
    load_nxt     = 1'b0;
    pc_nxt       = restart_pc;
    next_nxt     = restart_next;
    trap_nxt     = 1'b0;
    frc_nxt      = fast_rc_clock_sel;
    case (state_r)
      ST_BOOT: begin
        state_nxt    = ST_DELAY;
        dly_nxt      = start_dly(osc_source_config, 1'b0, power_up_sel);
        pll_wait_nxt = (osc_source_config == `RCW_OSC_PLL);
      end
      ST_RUN: begin
        if (power_save_instr) begin
          state_nxt = (power_save_mode == `RCW_PS_IDLE) ? ST_IDLE
                                                      : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_wdt | wake_irq) begin
          state_nxt    = ST_DELAY;
          in_reset_nxt = 1'b0;
          dly_nxt      = start_dly(current_osc_select,
                                   low_power_crystal_kept, power_up_sel);
          pll_wait_nxt = (current_osc_select == `RCW_OSC_PLL);
          res_pc_nxt   = wake_irq ? irq_vector : sleep_pc;
          res_next_nxt = ~wake_irq;
        end
      end
      ST_IDLE: begin
        if (wake_wdt | wake_irq) begin
          state_nxt = ST_RUN;
          load_nxt  = 1'b1;
          pc_nxt    = wake_irq ? irq_vector : sleep_pc;
          next_nxt  = ~wake_irq;
        end
      end
      ST_DELAY: begin
        if (pin_low && in_reset_r) begin
          dly_nxt = start_dly(rst_cls, 1'b0, power_up_sel);
        end else if (dly_r != 26'd0) begin
          dly_nxt = dly_r - 26'd1;
        end else if (clk_ok) begin
          state_nxt = ST_RUN;
          load_nxt  = 1'b1;
          pc_nxt    = res_pc_r;
          next_nxt  = res_next_r;
        end else if (clock_fail_monitor) begin
          state_nxt = ST_RUN;
          load_nxt  = 1'b1;
          trap_nxt  = 1'b1;
          frc_nxt   = 1'b1;
          pc_nxt    = `RCW_CFAIL_PC;
          next_nxt  = 1'b0;
        end else begin
          state_nxt = ST_STALL;
        end
      end
      ST_STALL: begin
        if (clk_ok) begin
          state_nxt = ST_RUN;
          load_nxt  = 1'b1;
          pc_nxt    = res_pc_r;
          next_nxt  = res_next_r;
        end
      end
      default: begin
        state_nxt = ST_BOOT;
      end
    endcase
    // any reset overrides the above and restarts from address zero
    if (any_reset && (state_r != ST_BOOT)) begin
      state_nxt    = ST_DELAY;
      in_reset_nxt = 1'b1;
      load_nxt     = 1'b0;
      trap_nxt     = 1'b0;
      dly_nxt      = start_dly(rst_cls, 1'b0, power_up_sel);
      pll_wait_nxt = (rst_cls == `RCW_OSC_PLL);
      res_pc_nxt   = `RCW_RESET_PC;
      res_next_nxt = 1'b0;
      if (brown_out_evt) begin
        frc_nxt = 1'b0;
      end
    end else if (load_nxt) begin
      in_reset_nxt = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r           <= ST_BOOT;
      dly_r             <= 26'd0;
      flags_r           <= `RCW_RESET_CAUSE_REGISTER_RST;
      wdt_cnt_r         <= {WDT_BITS{1'b0}};
      res_pc_r          <= `RCW_RESET_PC;
      res_next_r        <= 1'b0;
      in_reset_r        <= 1'b1;
      pll_wait_r        <= 1'b0;
      restart_load      <= 1'b0;
      restart_pc        <= `RCW_RESET_PC;
      restart_next      <= 1'b0;
      clk_fail_trap     <= 1'b0;
      fast_rc_clock_sel <= 1'b0;
      reg_rdata         <= 16'h0000;
    end else begin
      state_r           <= state_nxt;
      dly_r             <= dly_nxt;
      flags_r           <= flags_nxt;
      wdt_cnt_r         <= (any_reset | wake_wdt) ? {WDT_BITS{1'b0}}
                                                  : wdt_cnt_nxt;
      res_pc_r          <= res_pc_nxt;
      res_next_r        <= res_next_nxt;
      in_reset_r        <= in_reset_nxt;
      pll_wait_r        <= pll_wait_nxt;
      restart_load      <= load_nxt;
      restart_pc        <= pc_nxt;
      restart_next      <= next_nxt;
      clk_fail_trap     <= trap_nxt;
      fast_rc_clock_sel <= frc_nxt;
      // unmapped reads return zero
      reg_rdata         <= (reg_rd && (reg_addr == `RCW_RESET_CAUSE_REGISTER_OFF)) ?
                           flags_r : 16'h0000;
    end
  end

  // ==========================================================
  // clock gates, registered from the next state so they switch with it
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_reset_out   <= 1'b1;
      cpu_clk_en      <= 1'b0;
      periph_clk_en   <= 1'b0;
      osc_en          <= 1'b1;
      low_power_rc_en <= 1'b1;
    end else begin
      sys_reset_out   <= in_reset_nxt & (state_nxt != ST_RUN);
      cpu_clk_en      <= (state_nxt == ST_RUN);
      periph_clk_en   <= (state_nxt == ST_RUN) |
                         (state_nxt == ST_IDLE);
      osc_en          <= (state_nxt != ST_SLEEP) |
                         low_power_crystal_kept;
      // rc kept for the watchdog, or for the monitor when not asleep
      low_power_rc_en <= watchdog_active |
                         (clock_fail_monitor &
                          (state_nxt != ST_SLEEP));
    end
  end

endmodule
`default_nettype wire

// ---- rcw_ctrl_chk.sv ----
// rcw_ctrl_chk.sv: port assertions for the reset-cause and power-save block
`timescale 1ns/1ps
`default_nettype none
module rcw_ctrl_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        watchdog_config_enable,
  input wire logic        power_save_instr,
  input wire logic        power_save_mode,
  input wire logic        irq_wake,
  input wire logic [23:0] irq_vector,
  input wire logic        sys_reset_out,
  input wire logic        restart_load,
  input wire logic [23:0] restart_pc,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic [15:0] reset_cause_register,
  input wire logic        watchdog_active
);
  // ==========================================================
  // properties; one domain, so reset aborts every attempt
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // read data is a one-cycle copy of the flags, zero otherwise
  rd_data_a: assert property (reg_rd && reg_addr == 16'h0740
    |=> reg_rdata == $past(reset_cause_register))
    else $error("read data differs from flags");
  rd_zero_a: assert property (!(reg_rd && reg_addr == 16'h0740)
    |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  resv_bits_a: assert property (reset_cause_register[13:8] == 6'h00)
    else $error("unimplemented flag bits set");
  wdt_enable_a: assert property (
    watchdog_active == (watchdog_config_enable | reset_cause_register[5]))
    else $error("watchdog enable wrong");
  soft_write_a: assert property (
    reg_wr && reg_addr == 16'h0740
    |=> reset_cause_register[5] == $past(reg_wdata[5]))
    else $error("soft enable bit not written");
  // gates must change on the edge that takes the instruction
  idle_gate_a: assert property (
    cpu_clk_en && power_save_instr && power_save_mode
    |=> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
  sleep_gate_a: assert property (
    cpu_clk_en && power_save_instr && !power_save_mode
    |=> !cpu_clk_en && !periph_clk_en)
    else $error("sleep clock gating wrong");
  idle_wake_a: assert property (
    !cpu_clk_en && periph_clk_en && irq_wake
    |=> restart_load && restart_pc == $past(irq_vector) && cpu_clk_en
        && reset_cause_register[2])
    else $error("idle interrupt wake wrong");
  rst_cpu_a: assert property (sys_reset_out |-> !cpu_clk_en)
    else $error("cpu clock runs in reset");
endmodule
bind rcw_ctrl rcw_ctrl_chk rcw_ctrl_chk_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .watchdog_config_enable(watchdog_config_enable),
  .power_save_instr(power_save_instr), .power_save_mode(power_save_mode),
  .irq_wake(irq_wake), .irq_vector(irq_vector),
  .sys_reset_out(sys_reset_out), .restart_load(restart_load),
  .restart_pc(restart_pc), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en),
  .reset_cause_register(reset_cause_register),
  .watchdog_active(watchdog_active));
`default_nettype wire

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench for the reset-cause and power-save block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // stimulus, model state and design
  logic        sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, pin_n = 1;
  logic        rc = 0, rc_on = 0, wen = 0, clr = 0, psi = 0, psm = 0;
  logic        software_reset_flag = 0, trp = 0, irq = 0, oscr = 1, mon = 0, zero = 0;
  logic        pll = 1, restart_load, restart_next, clk_fail_trap;
  logic        sys_reset_out, fast_rc, cpu_clk_en, periph_clk_en;
  logic        osc_en, rc_en, wdt_on;
  logic [15:0] rcr;
  logic [1:0]  osc = 0;
  logic [3:0]  rc_div = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, mf;
  logic [23:0] irq_vector = 0, sleep_pc = 0, restart_pc;
  logic [15:0] set_t [5] = '{16'h0040, 16'h8000, 16'h0080, 16'h0084,
                             16'h0088};
  logic [15:0] clr_t [5] = '{16'h009c, 16'h0000, 16'h005c, 16'h0018,
                             16'h0014};
  int          num_errors = 0, samples_checked = 0;

  // short counts keep each wake delay to a few thousand cycles
  rcw_ctrl #(.WDT_BITS(3), .POWER_UP_TIMER_UNIT_CYC(20), .OST_CYC(4), .LOCK_CYC(4))
    rcw_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_reset_pin_n(pin_n),
    .low_power_rc_clock(rc), .watchdog_config_enable(wen),
    .watchdog_clear_instr(clr), .power_save_instr(psi),
    .power_save_mode(psm), .sw_reset_req(software_reset_flag), .brown_out_evt(zero),
    .trap_conflict_evt(trp), .illegal_op_evt(zero), .irq_wake(irq),
    .irq_vector(irq_vector), .sleep_pc(sleep_pc),
    .current_osc_select(osc), .osc_source_config(osc),
    .power_up_sel(2'h0), .low_power_crystal_kept(zero),
    .osc_running(oscr), .pll_lock(pll), .clock_fail_monitor(mon),
    .sys_reset_out(sys_reset_out), .restart_load(restart_load),
    .restart_pc(restart_pc), .restart_next(restart_next),
    .clk_fail_trap(clk_fail_trap), .fast_rc_clock_sel(fast_rc),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .low_power_rc_en(rc_en),
    .reset_cause_register(rcr), .watchdog_active(wdt_on));

  // 250 MHz clock; slow rc with one rising edge every 16 clocks
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    rc_div <= rc_div + 4'h1;
    if (rc_on) rc <= rc_div[3];
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic endt(input string n);
    logic [15:0] v;
    rd(16'h0740, v);
    chk({n, " flags"}, {16'h0, mf}, {16'h0, v});
    chk({n, " cause"}, {16'h0, mf}, {16'h0, rcr});
    $display("test %s finished", n);
  endtask
  // k: 0 software reset, 1 trap, 2 power-save with mode m
  task automatic evt(input int k, input logic m);
    @(posedge sys_clk);
    software_reset_flag <= (k == 0);
    trp <= (k == 1);
    psi <= (k == 2);
    psm <= m;
    @(posedge sys_clk);
    {software_reset_flag, trp, psi} <= 3'h0;
    tick(4);
  endtask
  // long enough to pass the pin filter
  task automatic pin;
    @(posedge sys_clk);
    pin_n <= 1'h0;
    tick(8);
    pin_n <= 1'h1;
  endtask
  // sampled mid-cycle so the one-cycle pulse is never missed
  task automatic wait_load(input logic [23:0] pc);
    for (int i = 0; i < 6000 && restart_load !== 1'h1; i++)
      @(negedge sys_clk);
    chk("restart", {8'h01, pc}, {7'h0, restart_load, restart_pc});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] d, v;
    logic [23:0] pc;
    int          i;
    i = $urandom(50143);
    tick(3);
    sys_rst <= 1'h0;
    wait_load(24'h0);
    mf = 16'h0003;
    endt("power_on");
    // soft enable kept off so no watchdog runs yet
    repeat (4) begin
      d = $urandom;
      wr(16'h0740, d & 16'hffdf);
      wr(16'h0742, ~d);
      mf = d & 16'hc0df;
      rd(16'h0742, v);
      chk("unmapped read", 0, v);
      endt("reg_rw");
    end
    // software, trap, pin in run, pin in idle, pin in sleep
    for (i = 0; i < 5; i++) begin
      if (i < 2) evt(i, 1'h0);
      else begin
        if (i > 2) evt(2, i == 3);
        pin();
      end
      mf = (mf & ~clr_t[i]) | set_t[i];
      wait_load(24'h0);
      endt("reset_kind");
    end
    // interrupt wake from idle, then from sleep
    for (i = 0; i < 2; i++) begin
      evt(2, i == 0);
      chk("cpu clock", 0, cpu_clk_en);
      chk("periph clock", i == 0, periph_clk_en);
      chk("osc on", i == 0, osc_en);
      chk("rc off", 0, rc_en);
      pc = $urandom;
      irq_vector <= pc;
      irq <= 1'h1;
      mf = mf | (i == 0 ? 16'h0004 : 16'h0008);
      wait_load(pc);
      tick(1);
      irq <= 1'h0;
      chk("cpu on", 1, cpu_clk_en);
      endt("irq_wake");
    end
    // crystal never starts after sleep: monitor traps to fast rc
    osc <= 2'h1;
    mon <= 1'h1;
    evt(2, 1'h0);
    oscr <= 1'h0;
    irq <= 1'h1;
    for (i = 0; i < 6000 && clk_fail_trap !== 1'h1; i++)
      @(negedge sys_clk);
    chk("fail trap", {8'h01, 24'h4}, {7'h0, clk_fail_trap, restart_pc});
    tick(1);
    {irq, mon, osc, oscr} <= 5'h01;
    tick(2);
    chk("fast rc", 1, fast_rc);
    mf = mf | 16'h0008;
    endt("clock_fail");
    // soft enable with periodic clears: no overflow, then overflow
    mf = mf | 16'h0020;
    wr(16'h0740, mf);
    rc_on <= 1'h1;
    repeat (20) begin
      tick(48);
      clr <= 1'h1;
      tick(1);
      clr <= 1'h0;
    end
    chk("no wdt reset", 0, sys_reset_out);
    wait_load(24'h0);
    mf = (mf & ~16'h00cc) | 16'h0010;
    endt("wdt_reset");
    rc_on <= 1'h0;
    // config bit alone keeps it on; timeout in sleep wakes instead
    mf = mf & ~16'h0020;
    wr(16'h0740, mf);
    wen <= 1'h1;
    pc = $urandom;
    sleep_pc <= pc;
    evt(2, 1'h0);
    chk("wdt on", 1, wdt_on);
    chk("rc in sleep", 1, rc_en);
    rc_on <= 1'h1;
    mf = mf | 16'h0018;
    wait_load(pc);
    chk("resume next", 1, restart_next);
    tick(1);
    rc_on <= 1'h0;
    wen <= 1'h0;
    endt("wdt_wake");
    finish_test();
  end

  // cuts a hang well past the expected run of about 106 us
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
